// File: hw/fault_mask_pkg.sv
// Constants, field positions and carrier types for the fault mask and suspend status block
// Assumes a byte-wide register port decoded by an outer serial engine
// Contract
// RULE1: Boost peak-current mask bit 7 blocks interrupt
// RULE2: Buck peak-current mask bit 6 blocks interrupt
// RULE3: Bits 5..2 mask four input lockout events
// RULE4: Mask bit 1 blocks thermal shutdown interrupt
// RULE5: Mask bit 0 blocks thermal warning interrupt
// RULE6: Zero unmasks; mask read/write, resets zero
// RULE7: Status bit 6 shows whole chip suspended
// RULE8: Status bit 5 shows boost suspended
// RULE9: Status bit 4 shows buck suspended
// RULE10: Status bits 3..0 show linear regulators suspended
// RULE11: Zero means normal; status resets zero
// RULE12: Masking gates output only; flags still recorded
// RULE13: Status bit 7 reads zero, ignores writes
package fault_mask_pkg;

	localparam logic [7:0] FAULT_IRQ_MASK_C_ADDR = 8'h19;
	localparam logic [7:0] SUSPEND_STATUS_ADDR   = 8'h1a;
	localparam logic [7:0] MASK_RESET            = 8'h00;
	localparam logic [7:0] STATUS_RESET          = 8'h00;
	localparam logic [7:0] FLAG_RESET            = 8'h00;
	localparam logic [7:0] READ_UNMAPPED         = 8'h00;
	localparam int         FAULT_EVENTS          = 8;
	localparam int         BIT_BOOST_IPK         = 7;
	localparam int         BIT_BUCK_IPK          = 6;
	localparam int         BIT_MAIN_UVLO         = 5;
	localparam int         BIT_PAIR_UVLO         = 4;
	localparam int         BIT_REG3_UVLO         = 3;
	localparam int         BIT_REG4_UVLO         = 2;
	localparam int         BIT_TSD               = 1;
	localparam int         BIT_TSD_WRN           = 0;
	localparam int         BIT_UNUSED            = 7;
	localparam int         BIT_CHIP_SUSPENDED         = 6;
	localparam int         BIT_STEPUP_SUSD       = 5;
	localparam int         BIT_STEPDOWN_SUSD     = 4;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic       chip;
		logic       stepup;
		logic       stepdown;
		logic [3:0] linreg;
	} suspend_s;

endpackage

// File: hw/fault_mask_status.sv
// Fault interrupt mask, event flags and suspend status for the power manager
// Assumes a byte register port driven by the serial engine on ref_clk_i
`timescale 1ns/100ps
module fault_mask_status
	import fault_mask_pkg::*;
(
	input  wire logic     ref_clk_i,
	input  wire logic     reset_i,
	input  wire reg_req_s req_i,
	input  wire logic [7:0] fault_event_i,
	input  wire suspend_s suspend_i,
	input  wire logic [7:0] flag_clear_i,
	output logic [7:0]    rdata_o,
	output logic [7:0]    fault_flags_o,
	output logic          irq_out_n_o,
	output logic          irq_out_n_oe_n_o
);

	////////////////////////////////////////////////////////////////////////
	// Synchronise asynchronous fault and suspend levels
	logic [7:0] event_sync;
	logic [6:0] susp_sync;

	pin_sync #(.WIDTH(8)) u_event_sync (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.async_i   (fault_event_i),
		.sync_o    (event_sync)
	);

	pin_sync #(.WIDTH(7)) u_susp_sync (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.async_i   (suspend_i),
		.sync_o    (susp_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// Decode
	logic       sel_mask;
	logic       sel_status;
	logic       wr_mask;
	logic [7:0] mask_q;
	logic [7:0] mask_d;
	logic [7:0] status_q;
	logic [7:0] status_d;
	logic [7:0] flag_q;
	logic [7:0] flag_d;
	logic [7:0] pending;
	logic [7:0] read_mux;

	assign sel_mask   = req_i.addr == FAULT_IRQ_MASK_C_ADDR;
	assign sel_status = req_i.addr == SUSPEND_STATUS_ADDR;
	assign wr_mask    = req_i.wr & sel_mask; // RULE6
	assign mask_d     = wr_mask ? req_i.wdata : mask_q; // RULE6

	// Writes to the status address fall through: the register has no write path
	assign status_d[BIT_UNUSED]        = 1'b0; // RULE13
	assign status_d[BIT_CHIP_SUSPENDED]     = susp_sync[6]; // RULE7 RULE11
	assign status_d[BIT_STEPUP_SUSD]   = susp_sync[5]; // RULE8 RULE11
	assign status_d[BIT_STEPDOWN_SUSD] = susp_sync[4]; // RULE9 RULE11
	assign status_d[3:0]               = susp_sync[3:0]; // RULE10 RULE11

	assign read_mux = sel_mask   ? mask_q   :
	                  sel_status ? status_q : READ_UNMAPPED;

	////////////////////////////////////////////////////////////////////////
	// Sticky flags, set wins over clear; mask never touches them
	genvar gi;
	generate
		for (gi = 0; gi < FAULT_EVENTS; gi++) begin : g_flag
			assign flag_d[gi]  = event_sync[gi] | (flag_q[gi] & ~flag_clear_i[gi]); // RULE12
			// Bit index equals mask bit position for each event
			assign pending[gi] = flag_q[gi] & ~mask_q[gi]; // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			mask_q   <= MASK_RESET;
			status_q <= STATUS_RESET;
			flag_q   <= FLAG_RESET;
		end else begin
			mask_q   <= mask_d;
			status_q <= status_d;
			flag_q   <= flag_d;
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_o <= READ_UNMAPPED;
		end else if (req_i.rd) begin
			rdata_o <= read_mux;
		end
	end

	// Open-drain pin: pull low only while an unmasked flag stands
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_out_n_o      <= 1'b0;
			irq_out_n_oe_n_o <= 1'b1;
			fault_flags_o    <= FLAG_RESET;
		end else begin
			// Drive value stays low; only the enable moves the pin
			irq_out_n_o      <= 1'b0;
			irq_out_n_oe_n_o <= ~(|pending); // RULE1 RULE2 RULE3 RULE4 RULE5
			fault_flags_o    <= flag_d; // RULE12
		end
	end

endmodule // fault_mask_status

// File: hw/pin_sync.sv
// Two-flop synchroniser, one per bit
// Assumes inputs arrive from analog fault comparators, asynchronous to ref_clk_i
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             ref_clk_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule // pin_sync

// File: tb/fault_mask_status_properties.sv
// Port checker for the fault mask block
// Assumes bind onto fault_mask_status
`timescale 1ns/100ps
module fault_mask_props
	import fault_mask_pkg::*;
(
	input wire logic       ref_clk_i,
	input wire logic       reset_i,
	input wire reg_req_s   req_i,
	input wire logic [7:0] fault_event_i,
	input wire suspend_s   suspend_i,
	input wire logic [7:0] rdata_o,
	input wire logic [7:0] fault_flags_o,
	input wire logic       irq_out_n_oe_n_o
);
	logic [7:0] m_q;
	wire        w19 = req_i.wr && req_i.addr == 8'h19, r1a = req_i.rd && req_i.addr == 8'h1a;
	wire  [7:0] live = fault_flags_o & ~m_q;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	always_ff @(posedge ref_clk_i or posedge reset_i) m_q <= reset_i ? 8'h00 : w19 ? req_i.wdata : m_q;
	sequence s_calm; $stable(suspend_i) [*4]; endsequence
	AST_FLAG: assert property (($past(fault_event_i, 3) & ~fault_flags_o) == 8'h00)
		else $error("flag lost");
	AST_BIT7: assert property (r1a |=> !rdata_o[7]) else $error("bit 7 set");
	AST_UNMAP: assert property (req_i.rd && req_i.addr > 8'h1a |=> rdata_o == 8'h00)
		else $error("unmapped read");
	AST_STAT: assert property (s_calm ##0 r1a |=> rdata_o[6:0] == $past(suspend_i))
		else $error("status wrong");
	AST_MASKED: assert property ((live == 8'h00) [*3] |-> irq_out_n_oe_n_o)
		else $error("masked pin low");
	AST_LIVE: assert property ((live != 8'h00) [*3] |-> !irq_out_n_oe_n_o) else $error("pin idle");
	AST_RST: assert property ($fell(reset_i) |-> irq_out_n_oe_n_o && fault_flags_o == 8'h00)
		else $error("reset state");
	AST_RDBK: assert property (w19 ##1 req_i.rd && req_i.addr == 8'h19 |=> rdata_o == $past(req_i.wdata, 2))
		else $error("mask readback");
endmodule // fault_mask_props
bind fault_mask_status fault_mask_props i_props (.*);

// File: tb/fault_mask_status_tb_top.sv
// Bench for the fault mask block
// Assumes bound checker and host pin model
`timescale 1ns/100ps
module fault_mask_status_tb_top;
	import fault_mask_pkg::*;
	logic       ref_clk_i = 0, reset_i = 1, irq_out_n_o, irq_out_n_oe_n_o, line;
	reg_req_s   req_i = '0;
	suspend_s   suspend_i = '0;
	logic [7:0] fault_event_i = 0, flag_clear_i = 0, rdata_o, fault_flags_o, m;
	int         err_count = 0, checked = 0;
	fault_mask_status i_dut (.*);
	irq_host_model i_host (.d_i(irq_out_n_o), .oe_n_i(irq_out_n_oe_n_o), .line_o(line));
	initial forever #5 ref_clk_i = ~ref_clk_i;
	function logic [7:0] stat(suspend_s s); return {1'b0, s}; endfunction
	task cmp(string n, logic [7:0] e, g);
		checked++;
		err_count += int'(g !== e);
		if (g !== e) $display("[FAIL] %s exp %h got %h", n, e, g);
	endtask
	task acc(logic w, logic [7:0] a, d, e);
		@(posedge ref_clk_i) req_i <= '{w, !w, a, d};
		@(posedge ref_clk_i) req_i <= '0;
		#1 if (!w) cmp("rdata", e, rdata_o);
	endtask
	task final_report;
		if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#100000 err_count++;
		final_report;
	end
	initial begin
		void'($urandom(72749));
		#80 reset_i = 0;
		acc(0, 8'h19, 0, 0);
		acc(1, 8'h1a, 8'hff, 0);
		acc(0, 8'h1a, 0, 0);
		acc(0, 8'h5c, 0, 0);
		@(posedge ref_clk_i) req_i <= '{1'b1, 1'b0, 8'h19, 8'h5a};
		@(posedge ref_clk_i) req_i <= '{1'b0, 1'b1, 8'h19, 8'h00};
		@(posedge ref_clk_i) req_i <= '0;
		#1 cmp("rdata", 8'h5a, rdata_o);
		for (int i = 0; i < 16; i++) begin
			m = 8'($urandom) & ~(8'h01 << i[2:0]) | 8'(i > 7) << i[2:0];
			acc(1, 8'h19, m, 0);
			@(posedge ref_clk_i) flag_clear_i <= 8'hff;
			@(posedge ref_clk_i) flag_clear_i <= 0;
			acc(0, 8'h19, 0, m);
			fault_event_i <= 8'h01 << i[2:0];
			suspend_i <= i < 15 ? 7'($urandom) : 7'h7f;
			repeat (5) @(posedge ref_clk_i);
			#1 cmp("pin", 8'(m[i[2:0]]), 8'(line));
			cmp("flags", 8'h01 << i[2:0], fault_flags_o);
			acc(0, 8'h1a, 0, stat(suspend_i));
			fault_event_i <= 0;
		end
		final_report;
	end
endmodule // fault_mask_status_tb_top

// File: tb/irq_host_model.sv
// Host end of the interrupt pin
// Assumes a pull-up on the line
`timescale 1ns/100ps
module irq_host_model (
	input  wire logic d_i,
	input  wire logic oe_n_i,
	output logic      line_o
);
	assign line_o = oe_n_i ? 1'b1 : d_i; // Released pin rises, never keeps last level
endmodule // irq_host_model
